// ==== hw/lac_top.sv ====
`timescale 1ns/1ps
module lac_top
  import lac_pkg::*;
#(
  parameter int SEC_CYCLES = SEC_CYC,
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int LOOP_SECS = LOOP_S,
  parameter int BUF_DEPTH = BUF_CELLS
) (
  input logic ref_clk,
  input logic srst,
  input logic [1:0] guard_switch_bank,
  input logic [11:0] config_switch_bank,
  input logic loop_button,
  input logic t3_rx_ais,
  input logic t3_rx_rai,
  input logic t3_rx_los,
  input logic t3_rx_lof,
  input logic t3_tx_ais,
  input logic t3_tx_rai,
  input logic t3_tx_los,
  input logic t2_rx_ais,
  input logic t2_rx_rai,
  input logic t2_rx_los,
  input logic t2_rx_lof,
  input logic cell_in,
  input logic cell_out,
  input logic selftest_done,
  input logic selftest_pass,
  input logic term_rxd,
  output logic term_txd,
  output logic selftest_start_ff,
  output logic cell_drop_ff,
  output logic [1:0] tx_timing_sel_ff,
  output logic [1:0] t3_cable_len_ff,
  output logic t2_cable_long_ff,
  output logic bpv_relay_en_ff,
  output logic test_mode_ff,
  output logic loop_relay_ff,
  output logic t3_rx_ais_led_ff,
  output logic t3_rx_rai_led_ff,
  output logic t3_rx_los_led_ff,
  output logic t3_rx_lof_led_ff,
  output logic t3_tx_ais_led_ff,
  output logic t3_tx_rai_led_ff,
  output logic t3_tx_los_led_ff,
  output logic t2_rx_ais_led_ff,
  output logic t2_rx_rai_led_ff,
  output logic t2_rx_los_led_ff,
  output logic t2_rx_lof_led_ff,
  output logic overflow_led_ff,
  output logic loop_led_ff,
  output logic active_led_ff,
  output logic fail_led_ff,
  output logic fractional_rate_indicator_ff
);
  localparam int SW = $clog2(SEC_CYCLES);
  localparam int HW = $clog2(HOLD_CYCLES);
  localparam int LW = $clog2(LOOP_SECS);
  localparam int BW = $clog2(BUF_DEPTH + 1);

  lac_st_t st_state_ff;
  logic [1:0] st_tries_ff;
  logic [SW-1:0] sec_cnt_ff;
  logic sec_tick_ff;
  logic [HW-1:0] hold_cnt_ff;
  logic btn_fired_ff;
  logic btn_press_ff;
  logic [LW-1:0] loop_secs_ff;
  logic tty_ovr_ff;
  lac_sync_t tty_sync_ff;
  lac_sync_t sw_sync;
  lac_sync_t nxt_sync;
  logic sync_los;
  logic rx_valid;
  logic [7:0] rx_data;
  logic tty_ok;
  logic tty_loop;
  logic [BW-1:0] occ_ff;
  logic tx_busy;
  logic tx_start_ff;
  logic [7:0] tx_char_ff;
  logic [2:0] diag_idx_ff;
  logic lamp_test;

  ////////////////////////////////////////////////////////////////////////
  lac_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
    .ref_clk(ref_clk),
    .srst(srst),
    .rxd(term_rxd),
    .rx_valid(rx_valid),
    .rx_data(rx_data)
  );

  lac_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
    .ref_clk(ref_clk),
    .srst(srst),
    .tx_start(tx_start_ff),
    .tx_data(tx_char_ff),
    .tx_busy(tx_busy),
    .txd(term_txd)
  );

  ////////////////////////////////////////////////////////////////////////
  // Switch decode; positions 5, 6, 10, 11, 12 are never looked at
  always_comb begin
    case ({config_switch_bank[CFG_SYNC_B], config_switch_bank[CFG_SYNC_A]})
      2'b10: sw_sync = SYNC_T3;
      2'b11: sw_sync = SYNC_T2;
      default: sw_sync = SYNC_INT;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      t3_cable_len_ff <= LEN_SHORT;
      t2_cable_long_ff <= 1'b0;
      bpv_relay_en_ff <= 1'b0;
      test_mode_ff <= 1'b0;
    end else begin
      case ({config_switch_bank[CFG_T3LEN_B],
             config_switch_bank[CFG_T3LEN_A]})
        2'b10: t3_cable_len_ff <= LEN_MED;
        2'b11: t3_cable_len_ff <= LEN_SHORT;
        default: t3_cable_len_ff <= LEN_LONG;
      endcase
      t2_cable_long_ff <= !config_switch_bank[CFG_T2LEN];
      bpv_relay_en_ff <= !config_switch_bank[CFG_BPV];
      test_mode_ff <= config_switch_bank[CFG_TEST];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Self test with up to two retries
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_state_ff <= ST_START;
      st_tries_ff <= '0;
      selftest_start_ff <= 1'b0;
    end else begin
      selftest_start_ff <= 1'b0;
      case (st_state_ff)
        ST_START: begin
          selftest_start_ff <= 1'b1;
          st_tries_ff <= st_tries_ff + 2'd1;
          st_state_ff <= ST_RUN;
        end
        ST_RUN: begin
          if (selftest_done && selftest_pass) begin
            st_state_ff <= ST_PASS;
          end else if (selftest_done) begin
            if (st_tries_ff == 2'(ST_TRIES)) begin
              st_state_ff <= ST_FAIL;
            end else begin
              st_state_ff <= ST_START;
            end
          end
        end
        ST_PASS: st_state_ff <= ST_PASS;
        ST_FAIL: st_state_ff <= ST_FAIL;
        default: st_state_ff <= ST_START;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // One-second enable, restarted on each loop operation so the
  // timeout is a full count of seconds, never one short
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      sec_cnt_ff <= '0;
      sec_tick_ff <= 1'b0;
    end else if (btn_press_ff || tty_loop) begin
      sec_cnt_ff <= '0;
      sec_tick_ff <= 1'b0;
    end else begin
      sec_tick_ff <= (sec_cnt_ff == SW'(SEC_CYCLES - 1));
      if (sec_cnt_ff == SW'(SEC_CYCLES - 1)) begin
        sec_cnt_ff <= '0;
      end else begin
        sec_cnt_ff <= sec_cnt_ff + SW'(1);
      end
    end
  end

  // Button must be held a full interval; one press per hold
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      hold_cnt_ff <= '0;
      btn_fired_ff <= 1'b0;
      btn_press_ff <= 1'b0;
    end else begin
      btn_press_ff <= 1'b0;
      if (!loop_button || !guard_switch_bank[GRD_LOOP]) begin
        hold_cnt_ff <= '0;
        btn_fired_ff <= 1'b0;
      end else if (!btn_fired_ff) begin
        if (hold_cnt_ff == HW'(HOLD_CYCLES - 1)) begin
          btn_press_ff <= 1'b1;
          btn_fired_ff <= 1'b1;
        end else begin
          hold_cnt_ff <= hold_cnt_ff + HW'(1);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Terminal commands only count while guard position 1 is down
  assign tty_ok = rx_valid && guard_switch_bank[GRD_TTY];
  assign tty_loop = tty_ok && rx_data == CH_LOOP;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tty_ovr_ff <= 1'b0;
      tty_sync_ff <= SYNC_INT;
    end else if (tty_ok) begin
      case (rx_data)
        CH_SYNC_T2: begin
          tty_ovr_ff <= 1'b1;
          tty_sync_ff <= SYNC_T2;
        end
        CH_SYNC_T3: begin
          tty_ovr_ff <= 1'b1;
          tty_sync_ff <= SYNC_T3;
        end
        CH_SYNC_INT: begin
          tty_ovr_ff <= 1'b1;
          tty_sync_ff <= SYNC_INT;
        end
        default: tty_ovr_ff <= tty_ovr_ff;
      endcase
    end
  end

  // Loop toggles on each operation, drops after the timeout
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      loop_relay_ff <= 1'b0;
      loop_secs_ff <= '0;
    end else if (btn_press_ff || tty_loop) begin
      loop_relay_ff <= !loop_relay_ff;
      loop_secs_ff <= '0;
    end else if (loop_relay_ff && sec_tick_ff) begin
      if (loop_secs_ff == LW'(LOOP_SECS - 1)) begin
        loop_relay_ff <= 1'b0;
        loop_secs_ff <= '0;
      end else begin
        loop_secs_ff <= loop_secs_ff + LW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Override holds only while the guard still permits it
  always_comb begin
    nxt_sync = sw_sync;
    if (tty_ovr_ff && guard_switch_bank[GRD_TTY]) begin
      nxt_sync = tty_sync_ff;
    end
  end

  assign sync_los = (nxt_sync == SYNC_T3 && t3_rx_los) ||
                    (nxt_sync == SYNC_T2 && t2_rx_los);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_timing_sel_ff <= SYNC_INT;
    end else if (sync_los) begin
      tx_timing_sel_ff <= SYNC_INT;
    end else begin
      tx_timing_sel_ff <= nxt_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Occupancy only; cell storage lives in the datapath
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      occ_ff <= '0;
      cell_drop_ff <= 1'b0;
    end else begin
      cell_drop_ff <= 1'b0;
      if (cell_in && !cell_out) begin
        if (occ_ff == BW'(BUF_DEPTH)) begin
          cell_drop_ff <= 1'b1;
        end else begin
          occ_ff <= occ_ff + BW'(1);
        end
      end else if (cell_out && !cell_in && occ_ff != '0) begin
        occ_ff <= occ_ff - BW'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Lamp test lights every lamp except active and fail while the self test runs
  assign lamp_test = (st_state_ff == ST_RUN);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      t3_rx_ais_led_ff <= 1'b0;
      t3_rx_rai_led_ff <= 1'b0;
      t3_rx_los_led_ff <= 1'b0;
      t3_rx_lof_led_ff <= 1'b0;
      t3_tx_ais_led_ff <= 1'b0;
      t3_tx_rai_led_ff <= 1'b0;
      t3_tx_los_led_ff <= 1'b0;
      t2_rx_ais_led_ff <= 1'b0;
      t2_rx_rai_led_ff <= 1'b0;
      t2_rx_los_led_ff <= 1'b0;
      t2_rx_lof_led_ff <= 1'b0;
    end else begin
      t3_rx_ais_led_ff <= lamp_test || t3_rx_ais;
      t3_rx_rai_led_ff <= lamp_test || t3_rx_rai;
      t3_rx_los_led_ff <= lamp_test || t3_rx_los;
      t3_rx_lof_led_ff <= lamp_test || t3_rx_lof;
      t3_tx_ais_led_ff <= lamp_test || t3_tx_ais;
      t3_tx_rai_led_ff <= lamp_test || t3_tx_rai;
      t3_tx_los_led_ff <= lamp_test || t3_tx_los;
      t2_rx_ais_led_ff <= lamp_test || t2_rx_ais;
      t2_rx_rai_led_ff <= lamp_test || t2_rx_rai;
      t2_rx_los_led_ff <= lamp_test || t2_rx_los;
      t2_rx_lof_led_ff <= lamp_test || t2_rx_lof;
    end
  end

  // Overflow stays lit until the buffer has fully drained
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      overflow_led_ff <= 1'b0;
      loop_led_ff <= 1'b0;
      active_led_ff <= 1'b0;
      fail_led_ff <= 1'b0;
      fractional_rate_indicator_ff <= 1'b0;
    end else begin
      overflow_led_ff <= lamp_test || cell_drop_ff ||
                         (overflow_led_ff && occ_ff != '0);
      loop_led_ff <= lamp_test || loop_relay_ff;
      active_led_ff <= (st_state_ff == ST_PASS);
      fail_led_ff <= (st_state_ff == ST_FAIL);
      fractional_rate_indicator_ff <= lamp_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status line repeats from reset: test state, three flag chars, CR
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_start_ff <= 1'b0;
      tx_char_ff <= '0;
      diag_idx_ff <= '0;
    end else begin
      tx_start_ff <= 1'b0;
      if (!tx_busy && !tx_start_ff) begin
        tx_start_ff <= 1'b1;
        diag_idx_ff <= (diag_idx_ff == 3'(DIAG_LEN - 1)) ?
                       3'h0 : diag_idx_ff + 3'h1;
        case (diag_idx_ff)
          3'h0: tx_char_ff <= (st_state_ff == ST_PASS) ? CH_PASS :
                              (st_state_ff == ST_FAIL) ? CH_FAIL :
                              CH_TESTING;
          3'h1: tx_char_ff <= {CH_FLAG_HI, t3_rx_ais, t3_rx_rai,
                               t3_rx_los, t3_rx_lof};
          3'h2: tx_char_ff <= {CH_FLAG_HI, t3_tx_ais, t3_tx_rai,
                               t3_tx_los, overflow_led_ff};
          3'h3: tx_char_ff <= {CH_FLAG_HI, t2_rx_ais, t2_rx_rai,
                               t2_rx_los, t2_rx_lof};
          default: tx_char_ff <= CH_CR;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  ovf_lamp_a: assert property (@(posedge ref_clk) disable iff (srst)
    cell_drop_ff |=> overflow_led_ff)
    else $error("overflow lamp missed a drop");

  t3rx_lamp_a: assert property (@(posedge ref_clk) disable iff (srst)
    (st_state_ff != ST_RUN) |=> t3_rx_lof_led_ff == $past(t3_rx_lof))
    else $error("t3 receive lof lamp wrong");

  t3tx_lamp_a: assert property (@(posedge ref_clk) disable iff (srst)
    (st_state_ff != ST_RUN) |=> t3_tx_los_led_ff == $past(t3_tx_los))
    else $error("t3 transmit los lamp wrong");

  t2rx_lamp_a: assert property (@(posedge ref_clk) disable iff (srst)
    (st_state_ff != ST_RUN && !t2_rx_ais) |=> !t2_rx_ais_led_ff)
    else $error("t2 receive ais lamp stuck");

  loop_lamp_a: assert property (@(posedge ref_clk) disable iff (srst)
    loop_relay_ff |=> loop_led_ff)
    else $error("loop lamp dark in loopback");

  st_pass_a: assert property (@(posedge ref_clk) disable iff (srst)
    (st_state_ff == ST_RUN && selftest_done && selftest_pass)
      |=> ##1 active_led_ff && !fail_led_ff)
    else $error("pass not shown green");

  st_retry_a: assert property (@(posedge ref_clk) disable iff (srst)
    $rose(fail_led_ff) |-> st_tries_ff == 2'(ST_TRIES))
    else $error("failure shown before last try");

  tty_guard_a: assert property (@(posedge ref_clk) disable iff (srst)
    (rx_valid && !guard_switch_bank[GRD_TTY]) |=> $stable(tty_sync_ff))
    else $error("terminal change taken while guarded");

  btn_guard_a: assert property (@(posedge ref_clk) disable iff (srst)
    !guard_switch_bank[GRD_LOOP] |=> !btn_press_ff)
    else $error("loop button acted while guarded");

  los_fall_a: assert property (@(posedge ref_clk) disable iff (srst)
    sync_los |=> tx_timing_sel_ff == SYNC_INT)
    else $error("no internal timing on los");

  buf_depth_a: assert property (@(posedge ref_clk) disable iff (srst)
    occ_ff <= BW'(BUF_DEPTH))
    else $error("occupancy above depth");

  fill_cv: cover property (@(posedge ref_clk) disable iff (srst)
    cell_drop_ff);
  fail_cv: cover property (@(posedge ref_clk) disable iff (srst)
    $rose(fail_led_ff));
  loop_cv: cover property (@(posedge ref_clk) disable iff (srst)
    $fell(loop_relay_ff) && !btn_press_ff && !tty_loop);
endmodule // lac_top

// ==== hw/lac_pkg.sv ====
package lac_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_BPS = 9600;
  localparam int BIT_CYC = CLK_HZ / BAUD_BPS;
  localparam int HOLD_MS = 1000;
  localparam int HOLD_CYC = (CLK_HZ / 1000) * HOLD_MS;
  localparam int SEC_CYC = CLK_HZ;
  localparam int LOOP_S = 3600;
  localparam int BUF_CELLS = 70;
  localparam int ST_TRIES = 3;
  localparam int DIAG_LEN = 5;
  // Guard bank positions, bit set means switch down
  localparam int GRD_TTY = 0;
  localparam int GRD_LOOP = 1;
  // Config bank positions, bit n-1 holds position n
  localparam int CFG_SYNC_A = 0;
  localparam int CFG_SYNC_B = 1;
  localparam int CFG_T3LEN_A = 2;
  localparam int CFG_T3LEN_B = 3;
  localparam int CFG_TEST = 6;
  localparam int CFG_BPV = 7;
  localparam int CFG_T2LEN = 8;
  localparam logic [7:0] CH_SYNC_T2 = 8'h30;
  localparam logic [7:0] CH_SYNC_T3 = 8'h31;
  localparam logic [7:0] CH_SYNC_INT = 8'h32;
  localparam logic [7:0] CH_LOOP = 8'h4C;
  localparam logic [7:0] CH_TESTING = 8'h54;
  localparam logic [7:0] CH_PASS = 8'h50;
  localparam logic [7:0] CH_FAIL = 8'h46;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [3:0] CH_FLAG_HI = 4'h4;

  typedef enum logic [1:0] {
    SYNC_INT = 2'b00,
    SYNC_T3 = 2'b01,
    SYNC_T2 = 2'b10
  } lac_sync_t;

  typedef enum logic [1:0] {
    LEN_LONG = 2'b00,
    LEN_MED = 2'b01,
    LEN_SHORT = 2'b11
  } lac_len_t;

  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_RUN = 2'b01,
    ST_PASS = 2'b11,
    ST_FAIL = 2'b10
  } lac_st_t;
endpackage

// ==== hw/lac_uart_tx.sv ====
`timescale 1ns/1ps
module lac_uart_tx #(
  parameter int BIT_CYC = 2604
) (
  input logic ref_clk,
  input logic srst,
  input logic tx_start,
  input logic [7:0] tx_data,
  output logic tx_busy,
  output logic txd
);
  localparam int CW = $clog2(BIT_CYC);
  logic [CW-1:0] cnt_ff;
  logic [3:0] idx_ff;
  logic [8:0] shr_ff;

  // Start bit, eight data bits LSB first, one stop bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_busy <= 1'b0;
      txd <= 1'b1;
      cnt_ff <= '0;
      idx_ff <= '0;
      shr_ff <= '1;
    end else if (!tx_busy && tx_start) begin
      tx_busy <= 1'b1;
      txd <= 1'b0;
      shr_ff <= {1'b1, tx_data};
      cnt_ff <= '0;
      idx_ff <= '0;
    end else if (tx_busy) begin
      if (cnt_ff == CW'(BIT_CYC - 1)) begin
        cnt_ff <= '0;
        if (idx_ff == 4'h9) begin
          tx_busy <= 1'b0;
        end else begin
          txd <= shr_ff[0];
          shr_ff <= {1'b1, shr_ff[8:1]};
          idx_ff <= idx_ff + 4'h1;
        end
      end else begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end
endmodule // lac_uart_tx

// ==== hw/lac_uart_rx.sv ====
`timescale 1ns/1ps
module lac_uart_rx #(
  parameter int BIT_CYC = 2604
) (
  input logic ref_clk,
  input logic srst,
  input logic rxd,
  output logic rx_valid,
  output logic [7:0] rx_data
);
  localparam int CW = $clog2(BIT_CYC);
  logic busy_ff;
  logic [CW-1:0] cnt_ff;
  logic [3:0] idx_ff;

  // First wait is half a bit, so every later sample lands mid-bit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      busy_ff <= 1'b0;
      cnt_ff <= '0;
      idx_ff <= '0;
      rx_valid <= 1'b0;
      rx_data <= '0;
    end else begin
      rx_valid <= 1'b0;
      if (!busy_ff) begin
        if (!rxd) begin
          busy_ff <= 1'b1;
          cnt_ff <= CW'(BIT_CYC / 2);
          idx_ff <= '0;
        end
      end else if (cnt_ff == CW'(BIT_CYC - 1)) begin
        cnt_ff <= '0;
        idx_ff <= idx_ff + 4'h1;
        if (idx_ff == 4'h0 && rxd) begin
          busy_ff <= 1'b0;
        end else if (idx_ff == 4'h9) begin
          busy_ff <= 1'b0;
          rx_valid <= rxd;
        end else if (idx_ff != 4'h0) begin
          rx_data <= {rxd, rx_data[7:1]};
        end
      end else begin
        cnt_ff <= cnt_ff + CW'(1);
      end
    end
  end
endmodule // lac_uart_rx

// ==== tb/lac_panel_model.sv ====
`timescale 1ns/1ps
module lac_panel_model
  import lac_pkg::*;
(
  input wire logic ref_clk,
  output logic term_rxd,
  output logic loop_button
);
  initial begin
    term_rxd = 1'b1;
    loop_button = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Terminal frames: 8N1, LSB first, idle high, no handshake lines
  task automatic send_char(input logic [7:0] ch);
    logic [9:0] frame;
    frame = {1'b1, ch, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge ref_clk) #1;
      term_rxd = frame[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
  endtask

  // Held press, long enough for the anti-accident count
  task automatic press(input int cyc);
    @(posedge ref_clk) #1;
    loop_button = 1'b1;
    repeat (cyc) @(posedge ref_clk);
    #1;
    loop_button = 1'b0;
  endtask
endmodule // lac_panel_model

// ==== tb/line_adapter_config_status_test.sv ====
`timescale 1ns/1ps
module line_adapter_config_status_test;
  import lac_pkg::*;
  localparam int SEC_T = 20;
  localparam int HOLD_T = 10;
  localparam int LOOP_T = 3;
  localparam int DEPTH = 70;
  logic ref_clk, srst, cell_in, cell_out, selftest_done, selftest_pass;
  logic [1:0] guard_switch_bank;
  logic [11:0] config_switch_bank;
  logic [10:0] alarm_in, led;
  logic term_rxd, loop_button, term_txd, selftest_start_ff, cell_drop_ff;
  logic [1:0] tx_timing_sel_ff, t3_cable_len_ff;
  logic t2_cable_long_ff, bpv_relay_en_ff, loop_relay_ff, overflow_led_ff;
  logic loop_led_ff, active_led_ff, fail_led_ff, fractional_rate_indicator_ff;
  logic test_mode_ff;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Switch cases: config bank, alarms, {sync, t3 len, t2 long, relay}
  logic [11:0] cfg_tab [11] = '{12'h000, 12'h002, 12'h003, 12'h00C,
    12'h008, 12'h080, 12'h100, 12'hE30, 12'h002, 12'h003, 12'h003};
  logic [10:0] alm_tab [11] = '{11'h000, 11'h000, 11'h000, 11'h000,
    11'h000, 11'h000, 11'h000, 11'h000, 11'h100, 11'h002, 11'h100};
  logic [5:0] exp_tab [11] = '{6'h03, 6'h13, 6'h23, 6'h0F, 6'h07, 6'h02,
    6'h01, 6'h03, 6'h03, 6'h03, 6'h23};

  lac_top #(.SEC_CYCLES(SEC_T), .HOLD_CYCLES(HOLD_T), .LOOP_SECS(LOOP_T),
    .BUF_DEPTH(DEPTH)) dut (.ref_clk, .srst, .guard_switch_bank,
    .config_switch_bank, .loop_button, .t3_rx_ais(alarm_in[10]),
    .t3_rx_rai(alarm_in[9]), .t3_rx_los(alarm_in[8]), .t3_rx_lof(alarm_in[7]),
    .t3_tx_ais(alarm_in[6]), .t3_tx_rai(alarm_in[5]), .t3_tx_los(alarm_in[4]),
    .t2_rx_ais(alarm_in[3]), .t2_rx_rai(alarm_in[2]), .t2_rx_los(alarm_in[1]),
    .t2_rx_lof(alarm_in[0]), .cell_in, .cell_out, .selftest_done,
    .selftest_pass, .term_rxd, .term_txd, .selftest_start_ff, .cell_drop_ff,
    .tx_timing_sel_ff, .t3_cable_len_ff, .t2_cable_long_ff, .bpv_relay_en_ff,
    .test_mode_ff, .loop_relay_ff, .t3_rx_ais_led_ff(led[10]),
    .t3_rx_rai_led_ff(led[9]), .t3_rx_los_led_ff(led[8]),
    .t3_rx_lof_led_ff(led[7]), .t3_tx_ais_led_ff(led[6]),
    .t3_tx_rai_led_ff(led[5]), .t3_tx_los_led_ff(led[4]),
    .t2_rx_ais_led_ff(led[3]), .t2_rx_rai_led_ff(led[2]),
    .t2_rx_los_led_ff(led[1]), .t2_rx_lof_led_ff(led[0]), .overflow_led_ff,
    .loop_led_ff, .active_led_ff, .fail_led_ff,
    .fractional_rate_indicator_ff);

  lac_panel_model panel (.ref_clk, .term_rxd, .loop_button);

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Two terminal characters dominate the run length
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      num_errors++;
      conclude();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [11:0] seen,
                       input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic do_reset();
    srst = 1'b1;
    tick(5);
    srst = 1'b0;
  endtask

  // One attempt: wait for the start pulse, answer the next cycle
  task automatic run_attempt(input logic ok);
    int n;
    n = 0;
    while (selftest_start_ff !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    check("selftest_start_ff", selftest_start_ff, 1'b1);
    tick(1);
    check("lamp test", {led, overflow_led_ff}, 12'hFFF);
    selftest_done = 1'b1;
    selftest_pass = ok;
    tick(1);
    selftest_done = 1'b0;
    tick(1);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cell_in = 1'b0;
    cell_out = 1'b0;
    selftest_done = 1'b0;
    selftest_pass = 1'b0;
    alarm_in = '0;
    guard_switch_bank = 2'b00;
    config_switch_bank = 12'h10C;
    do_reset();
    run_attempt(1'b0);
    run_attempt(1'b0);
    run_attempt(1'b1);
    check("active_led_ff", {active_led_ff, fail_led_ff}, 2'b10);
    check("term_txd", term_txd, 1'b0);
    check("fractional", fractional_rate_indicator_ff, 1'b0);
    for (int i = 0; i < 11; i++) begin
      alarm_in = 11'h001 << i;
      tick(1);
      check("alarm lamps", led, alarm_in);
    end
    alarm_in = '0;
    tick(1);
    check("alarm lamps clear", led, 11'h000);
    for (int i = 0; i < 11; i++) begin
      config_switch_bank = cfg_tab[i];
      alarm_in = alm_tab[i];
      tick(1);
      check("settings", {tx_timing_sel_ff, t3_cable_len_ff, t2_cable_long_ff,
        bpv_relay_en_ff}, exp_tab[i]);
    end
    alarm_in = '0;
    config_switch_bank = 12'h040;
    tick(1);
    check("test_mode_ff", test_mode_ff, 1'b1);
    config_switch_bank = 12'h000;
    // Back-to-back arrivals: the 71st has no room
    cell_in = 1'b1;
    tick(DEPTH);
    check("cell_drop_ff full", cell_drop_ff, 1'b0);
    tick(1);
    cell_in = 1'b0;
    check("cell_drop_ff", cell_drop_ff, 1'b1);
    tick(1);
    check("overflow_led_ff", overflow_led_ff, 1'b1);
    cell_out = 1'b1;
    tick(DEPTH);
    cell_out = 1'b0;
    tick(2);
    check("overflow_led_ff empty", overflow_led_ff, 1'b0);
    panel.press(HOLD_T + 4);
    tick(3);
    check("loop guarded", loop_relay_ff, 1'b0);
    guard_switch_bank = 2'b10;
    panel.press(HOLD_T + 4);
    tick(1);
    check("loop on", {loop_relay_ff, loop_led_ff}, 2'b11);
    panel.press(HOLD_T + 4);
    tick(1);
    check("loop off", {loop_relay_ff, loop_led_ff}, 2'b00);
    panel.press(HOLD_T + 4);
    tick(30);
    check("loop held", loop_relay_ff, 1'b1);
    tick(40);
    check("loop expired", loop_relay_ff, 1'b0);
    guard_switch_bank = 2'b00;
    panel.send_char(CH_SYNC_T3);
    tick(2);
    check("terminal refused", tx_timing_sel_ff, 2'b00);
    guard_switch_bank = 2'b01;
    panel.send_char(CH_SYNC_T3);
    tick(2);
    check("terminal sync", tx_timing_sel_ff, 2'b01);
    guard_switch_bank = 2'b00;
    tick(2);
    check("switch sync back", tx_timing_sel_ff, 2'b00);
    do_reset();
    run_attempt(1'b0);
    run_attempt(1'b0);
    run_attempt(1'b0);
    check("fail_led_ff", {active_led_ff, fail_led_ff}, 2'b01);
    conclude();
  end
endmodule // line_adapter_config_status_test
